// ### rtl/stfm_top.sv
// supply trip filter monitor: comparator filtering, trip reset, status flag
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module stfm_top (
  input wire logic clk, // cpu clock, 100 MHz
  input wire logic rst_n, // power-on reset, synchronous, active low
  input wire logic dev_rst_pulse, // any other device reset, one cycle
  input wire logic cmp_below_fall, // comparator: supply below falling level
  input wire logic cmp_above_rise, // comparator: supply above rising level
  input wire logic oscillator_clock, // crystal oscillator output
  input wire logic stop_mode, // cpu is in stop mode
  input wire logic [stfm_pkg::ADDR_W-1:0] addr, // register address
  input wire logic [stfm_pkg::DATA_W-1:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [stfm_pkg::DATA_W-1:0] rd_data_q, // read data, next cycle
  output logic mon_reset_q, // reset request to system reset logic
  output logic rst_pin_out_q, // external reset pin drive value
  output logic rst_pin_oe_q, // external reset pin pulled low
  output logic low_supply_flag_q, // polled low supply status
  output logic irq_q // system event line
);
  import stfm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic below_m_q, below_s;
  logic above_m_q, above_s;
  logic osc_m_q, osc_s, osc_prev_q;
  logic osc_rise;

  // comparator and oscillator are asynchronous to clk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      below_m_q <= 1'b0;
      below_s <= 1'b0;
      above_m_q <= 1'b0;
      above_s <= 1'b0;
      osc_m_q <= 1'b0;
      osc_s <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      below_m_q <= cmp_below_fall;
      below_s <= below_m_q;
      above_m_q <= cmp_above_rise;
      above_s <= above_m_q;
      osc_m_q <= oscillator_clock;
      osc_s <= osc_m_q;
      osc_prev_q <= osc_s;
    end
  end

  // oscillator edges gate the flag timer; clk must run faster than twice it
  assign osc_rise = osc_s & ~osc_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // option register
  logic opt_pwr_dis_q, opt_rst_dis_q, opt_stop_en_q;
  logic opt_pwr_dis_d, opt_rst_dis_d, opt_stop_en_d;
  logic opt_wr;

  assign opt_wr = wr_en && (addr == OPTION_ADDR);

  always_comb begin
    opt_pwr_dis_d = opt_pwr_dis_q;
    opt_rst_dis_d = opt_rst_dis_q;
    opt_stop_en_d = opt_stop_en_q;
    if (opt_wr) begin
      opt_pwr_dis_d = wr_data[OPT_PWR_DIS_BIT];
      opt_rst_dis_d = wr_data[OPT_RST_DIS_BIT];
      opt_stop_en_d = wr_data[OPT_STOP_EN_BIT];
    end
  end

  // reset value zero: powered with resets on, no software needed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opt_pwr_dis_q <= OPTION_RESET[OPT_PWR_DIS_BIT];
      opt_rst_dis_q <= OPTION_RESET[OPT_RST_DIS_BIT];
      opt_stop_en_q <= OPTION_RESET[OPT_STOP_EN_BIT];
    end else begin
      opt_pwr_dis_q <= opt_pwr_dis_d;
      opt_rst_dis_q <= opt_rst_dis_d;
      opt_stop_en_q <= opt_stop_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // activity qualifiers
  logic active;
  logic rst_en;
  logic below_act;

  // wait mode does not appear here: the monitor keeps running in it
  assign active = !opt_pwr_dis_q && !(stop_mode && !opt_stop_en_q);
  assign rst_en = !opt_rst_dis_q;
  assign below_act = active && below_s;

  ////////////////////////////////////////////////////////////////////////////
  // filters: cpu cycles for the reset, oscillator edges for the flag
  logic trip_reached;
  logic flag_reached;

  stfm_run_counter #(
    .THRESH(TRIP_CYCLES)
  ) u_trip_filter (
    .clk(clk),
    .rst_n(rst_n),
    .clear(!below_act),
    .step(below_act),
    .reached_q(trip_reached)
  );

  stfm_run_counter #(
    .THRESH(FLAG_OSC_EDGES)
  ) u_flag_filter (
    .clk(clk),
    .rst_n(rst_n),
    .clear(!below_act),
    .step(below_act && osc_rise),
    .reached_q(flag_reached)
  );

  ////////////////////////////////////////////////////////////////////////////
  // trip state machine
  stfm_state_type state_q, state_d;
  logic stop_bypass;

  // cpu clocks stop in stop mode, so the filter cannot be trusted there
  assign stop_bypass = stop_mode && opt_stop_en_q && below_s;

  always_comb begin
    state_d = state_q;
    case (state_q)
      MON_OK: begin
        if (active && rst_en && (trip_reached || stop_bypass)) begin
          state_d = MON_TRIP;
        end
      end
      MON_TRIP: begin
        if (above_s) begin
          state_d = MON_OK;
        end
      end
      default: begin
        state_d = MON_OK;
      end
    endcase
  end

  // rst_n must be power-on only; a trip must not clear its own state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= MON_OK;
      mon_reset_q <= 1'b0;
      rst_pin_out_q <= 1'b0;
      rst_pin_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mon_reset_q <= (state_d == MON_TRIP);
      rst_pin_out_q <= 1'b0; // open drain: only ever pulls low
      rst_pin_oe_q <= (state_d == MON_TRIP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low supply flag
  logic flag_d;

  // reset and rising level both clear; between levels the flag holds
  always_comb begin
    flag_d = low_supply_flag_q;
    if (dev_rst_pulse) begin
      flag_d = 1'b0;
    end else if (above_s) begin
      flag_d = 1'b0;
    end else if (active && flag_reached) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_supply_flag_q <= 1'b0;
    end else begin
      low_supply_flag_q <= flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system events: sticky status, write-one clear, enable
  logic [EVT_W-1:0] evt_stat_q, evt_stat_d;
  logic [EVT_W-1:0] evt_en_q, evt_en_d;
  logic [EVT_W-1:0] evt_raw;
  logic [EVT_W-1:0] evt_clr;
  logic irq_d;

  always_comb begin
    evt_raw = '0;
    evt_raw[EVT_TRIP_BIT] = (state_q == MON_OK) && (state_d == MON_TRIP);
    evt_raw[EVT_RELEASE_BIT] = (state_q == MON_TRIP) && (state_d == MON_OK);
    evt_raw[EVT_FLAG_BIT] = !low_supply_flag_q && flag_d;
    evt_clr = '0;
    if (wr_en && (addr == EVT_CLR_ADDR)) begin
      evt_clr = wr_data[EVT_W-1:0];
    end
    evt_en_d = evt_en_q;
    if (wr_en && (addr == EVT_EN_ADDR)) begin
      evt_en_d = wr_data[EVT_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    evt_stat_d = (evt_stat_q & ~evt_clr) | evt_raw;
    // no cpu interrupt from the monitor; this line is system bookkeeping
    irq_d = |(evt_stat_d & evt_en_d);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_stat_q <= EVT_RESET;
      evt_en_q <= EVT_RESET;
      irq_q <= 1'b0;
    end else begin
      evt_stat_q <= evt_stat_d;
      evt_en_q <= evt_en_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port
  logic [DATA_W-1:0] rd_data_d;

  // data stands for one cycle only; unmapped and write-only read zero
  always_comb begin
    rd_data_d = '0;
    if (rd_en) begin
      if (addr == STATUS_ADDR) begin
        rd_data_d[FLAG_BIT] = low_supply_flag_q;
      end else if (addr == OPTION_ADDR) begin
        rd_data_d[OPT_PWR_DIS_BIT] = opt_pwr_dis_q;
        rd_data_d[OPT_RST_DIS_BIT] = opt_rst_dis_q;
        rd_data_d[OPT_STOP_EN_BIT] = opt_stop_en_q;
      end else if (addr == EVT_STAT_ADDR) begin
        rd_data_d[EVT_W-1:0] = evt_stat_q;
      end else if (addr == EVT_EN_ADDR) begin
        rd_data_d[EVT_W-1:0] = evt_en_q;
      end
    end
  end

  // writes to the status address are ignored: flag is read-only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers: independent runs of below-trip samples
  logic [CNT_W-1:0] below_run_q;
  logic [CNT_W-1:0] osc_run_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      below_run_q <= '0;
      osc_run_q <= '0;
    end else begin
      below_run_q <= below_act ? stfm_sat_inc(below_run_q) : '0;
      if (!below_act) begin
        osc_run_q <= '0;
      end else if (osc_rise) begin
        osc_run_q <= stfm_sat_inc(osc_run_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_trip_after_nine: assert property (
    $rose(mon_reset_q) && !$past(stop_mode) |-> $past(below_run_q) >= TRIP_CYCLES)
    else $error("trip reset before nine below-trip cycles");

  a_release_one_cycle: assert property (
    mon_reset_q && above_s |=> !mon_reset_q)
    else $error("reset not released after one cycle above rising level");

  a_pin_follows_trip: assert property (
    rst_pin_oe_q == mon_reset_q && !rst_pin_out_q)
    else $error("external reset pin does not follow monitor reset");

  a_reset_suppressed: assert property (
    opt_rst_dis_q && !mon_reset_q |=> !mon_reset_q)
    else $error("trip reset raised while resets disabled");

  a_flag_not_early: assert property (
    $rose(low_supply_flag_q) |-> $past(osc_run_q) >= FLAG_MIN_EDGES)
    else $error("flag set before 32 oscillator edges");

  a_flag_set_late: assert property (
    below_act && osc_run_q > FLAG_MAX_EDGES && !dev_rst_pulse
    |-> ##2 (low_supply_flag_q || above_s || $past(dev_rst_pulse)))
    else $error("flag not set after 40 oscillator edges");

  a_flag_clear_above: assert property (
    above_s |=> !low_supply_flag_q)
    else $error("flag set while supply above rising level");

  a_flag_hold_between: assert property (
    !above_s && !flag_reached && !dev_rst_pulse |=> $stable(low_supply_flag_q))
    else $error("flag changed between trip levels");

  a_stop_bypass: assert property (
    stop_mode && opt_stop_en_q && !opt_pwr_dis_q && rst_en && below_s
    && !mon_reset_q |=> mon_reset_q)
    else $error("stop mode trip did not reset directly");

  a_stop_inactive: assert property (
    stop_mode && !opt_stop_en_q && !mon_reset_q |=> !mon_reset_q)
    else $error("monitor tripped in stop mode while disabled there");

  a_status_read: assert property (
    rd_en && addr == STATUS_ADDR
    |=> rd_data_q == {$past(low_supply_flag_q), 7'h00})
    else $error("status read does not show the flag in bit 7");

  c_filtered_trip: cover property ($rose(mon_reset_q) && !$past(stop_mode));
  c_release: cover property ($fell(mon_reset_q));
  c_flag_set: cover property ($rose(low_supply_flag_q));
  c_stop_trip: cover property (stop_mode && $rose(mon_reset_q));

endmodule : stfm_top

// ### rtl/stfm_pkg.sv
// constants and helpers shared by the supply trip filter monitor
package stfm_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CNT_W = 6;

  // register map
  localparam logic [15:0] STATUS_ADDR = 16'hfe0f;
  localparam logic [15:0] OPTION_ADDR = 16'hfe10;
  localparam logic [15:0] EVT_STAT_ADDR = 16'hfe11;
  localparam logic [15:0] EVT_CLR_ADDR = 16'hfe12;
  localparam logic [15:0] EVT_EN_ADDR = 16'hfe13;

  // field positions
  localparam int FLAG_BIT = 7;
  localparam int OPT_PWR_DIS_BIT = 0;
  localparam int OPT_RST_DIS_BIT = 1;
  localparam int OPT_STOP_EN_BIT = 2;
  localparam int EVT_TRIP_BIT = 0;
  localparam int EVT_RELEASE_BIT = 1;
  localparam int EVT_FLAG_BIT = 2;
  localparam int EVT_W = 3;

  // reset values: powered, resets on, stop mode and event enables off, nothing pending
  localparam logic [2:0] OPTION_RESET = 3'h0;
  localparam logic [2:0] EVT_RESET = 3'h0;

  // filter lengths
  localparam logic [CNT_W-1:0] TRIP_CYCLES = 6'h09;
  localparam logic [CNT_W-1:0] FLAG_OSC_EDGES = 6'h24;
  localparam logic [CNT_W-1:0] FLAG_MIN_EDGES = 6'h20;
  localparam logic [CNT_W-1:0] FLAG_MAX_EDGES = 6'h28;

  typedef enum logic {
    MON_OK = 1'b0,
    MON_TRIP = 1'b1
  } stfm_state_type;

  // saturating increment, shared by the filters and their checks
  function automatic logic [CNT_W-1:0] stfm_sat_inc(input logic [CNT_W-1:0] v);
    stfm_sat_inc = (v == 6'h3f) ? v : v + 6'h01;
  endfunction : stfm_sat_inc

endpackage : stfm_pkg

// ### rtl/stfm_run_counter.sv
// consecutive-event counter with threshold flag
`timescale 1ns/1ps
module stfm_run_counter #(
  parameter logic [stfm_pkg::CNT_W-1:0] THRESH = 6'h01 // count to reach
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic clear, // restart the run from zero
  input wire logic step, // one more qualifying event
  output logic reached_q // run has reached the threshold
);
  import stfm_pkg::*;

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic reached_d;

  // clear beats step so a broken run never carries over
  always_comb begin
    count_d = count_q;
    if (clear) begin
      count_d = '0;
    end else if (step) begin
      count_d = stfm_sat_inc(count_q);
    end
    reached_d = (count_d >= THRESH);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
      reached_q <= 1'b0;
    end else begin
      count_q <= count_d;
      reached_q <= reached_d;
    end
  end

endmodule : stfm_run_counter

// ### sim/stfm_supply_model.sv
// supply comparator and crystal oscillator model for the trip monitor
`timescale 1ns/1ps
module stfm_supply_model (
  input wire logic [1:0] level, // 0 below fall, 1 between, 2 above rise
  output logic cmp_below_fall, // supply below falling level
  output logic cmp_above_rise, // supply above rising level
  output logic oscillator_clock // free running crystal output
);
  ////////////////////////////////////////////////////////////////////////////
  // comparators: the two levels never report at once, as in the analog part
  assign cmp_below_fall = (level == 2'h0);
  assign cmp_above_rise = (level == 2'h2);

  ////////////////////////////////////////////////////////////////////////////
  // crystal runs free, 60 ns period, phase unrelated to the cpu clock
  initial begin
    oscillator_clock = 1'b0;
    #7;
    forever begin
      #30 oscillator_clock = ~oscillator_clock;
    end
  end
endmodule : stfm_supply_model

// ### sim/stfm_top_test.sv
// self-checking bench for the supply trip filter monitor
`timescale 1ns/1ps
`define STFM_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("ERROR %s exp=%h got=%h", nm, e, g); end end
module stfm_top_test;
  import stfm_pkg::*;
  typedef struct packed {logic kind; logic [7:0] exp;} stfm_note_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dev_rst_pulse = 1'b0;
  logic stop_mode = 1'b0;
  logic [1:0] level = 2'h2;
  logic [15:0] addr = 16'h0;
  logic [7:0] wr_data = 8'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic probe = 1'b0;
  logic rd_seen = 1'b0;
  logic [15:0] rd_addr_q = 16'h0;
  logic cmp_below_fall, cmp_above_rise, oscillator_clock;
  logic [7:0] rd_data_q;
  logic mon_reset_q, rst_pin_out_q, rst_pin_oe_q, low_supply_flag_q, irq_q;
  stfm_note_type notes[$];
  stfm_note_type n;
  int err_total = 0;
  int compares = 0;

  always #5 clk = ~clk;

  stfm_supply_model model (.level(level), .cmp_below_fall(cmp_below_fall),
    .cmp_above_rise(cmp_above_rise), .oscillator_clock(oscillator_clock));

  stfm_top dut (.clk(clk), .rst_n(rst_n), .dev_rst_pulse(dev_rst_pulse),
    .cmp_below_fall(cmp_below_fall), .cmp_above_rise(cmp_above_rise),
    .oscillator_clock(oscillator_clock), .stop_mode(stop_mode),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data_q(rd_data_q), .mon_reset_q(mon_reset_q),
    .rst_pin_out_q(rst_pin_out_q), .rst_pin_oe_q(rst_pin_oe_q),
    .low_supply_flag_q(low_supply_flag_q), .irq_q(irq_q));

  ////////////////////////////////////////////////////////////////////////////
  // monitor: read data or a probe is a result; match it to the oldest note
  always @(posedge clk) begin
    rd_seen <= rd_en;
    rd_addr_q <= addr;
  end
  always @(negedge clk) begin
    if (rd_seen || probe) begin
      if (notes.size() == 0) begin
        err_total++;
        $display("ERROR result with no expectation");
      end else begin
        n = notes.pop_front();
        if (n.kind) `STFM_CHK("outputs", n.exp, {4'h0, mon_reset_q,
          rst_pin_oe_q, rst_pin_out_q, irq_q})
        else `STFM_CHK("rd_data_q", n.exp, rd_data_q)
        // the flag pin itself must agree with what the status read showed
        if (!n.kind && rd_addr_q == STATUS_ADDR)
          `STFM_CHK("low_supply_flag_q", n.exp[7], low_supply_flag_q)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus tasks; each leaves an idle edge so no strobe is set twice at once
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    addr <= a;
    rd_en <= 1'b1;
    notes.push_back({1'b0, e});
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask : rd

  // expected {mon_reset, pin enable, pin value, irq}
  task automatic chk_out(input logic [3:0] e);
    probe <= 1'b1;
    notes.push_back({1'b1, 4'h0, e});
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask : chk_out

  task automatic summarize;
    if (notes.size() != 0) err_total++;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs about 730 cycles
  initial begin
    #500000;
    err_total++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int dur;
    dur = $urandom(6);
    cyc(6);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(STATUS_ADDR, 8'h00);
    rd(OPTION_ADDR, 8'h00);
    chk_out(4'h0);
    // short dips broken by a between-levels cycle never trip
    dur = $urandom_range(7, 3);
    level <= 2'h0;
    cyc(dur);
    level <= 2'h1;
    cyc(1);
    level <= 2'h0;
    cyc(7);
    level <= 2'h1;
    cyc(3);
    chk_out(4'h0);
    // a full run trips and pulls the reset pin low
    level <= 2'h0;
    cyc(8);
    chk_out(4'h0);
    cyc(4);
    chk_out(4'hc);
    level <= 2'h1;
    cyc(10);
    chk_out(4'hc);
    level <= 2'h2;
    cyc(1);
    level <= 2'h1;
    cyc(4);
    chk_out(4'h0);
    rd(STATUS_ADDR, 8'h00);
    // events: trip and release pending, enabled, masked again, then cleared
    rd(EVT_STAT_ADDR, 8'h03);
    wr(EVT_EN_ADDR, 8'h01);
    chk_out(4'h1);
    wr(EVT_EN_ADDR, 8'h00);
    chk_out(4'h0);
    wr(EVT_CLR_ADDR, 8'h03);
    rd(EVT_STAT_ADDR, 8'h00);
    // status is read only; unmapped space reads zero
    wr(STATUS_ADDR, 8'($urandom()));
    rd(STATUS_ADDR, 8'h00);
    rd(16'h1234, 8'h00);
    // polled mode: no reset, flag timed by the oscillator
    wr(OPTION_ADDR, 8'h02);
    wr(EVT_EN_ADDR, 8'h04);
    level <= 2'h0;
    cyc(176);
    rd(STATUS_ADDR, 8'h00);
    cyc(84);
    rd(STATUS_ADDR, 8'h80);
    chk_out(4'h1);
    level <= 2'h1;
    cyc(10);
    rd(STATUS_ADDR, 8'h80);
    level <= 2'h2;
    cyc(4);
    rd(STATUS_ADDR, 8'h00);
    wr(EVT_CLR_ADDR, 8'h04);
    chk_out(4'h0);
    level <= 2'h0;
    cyc(264);
    level <= 2'h1;
    rd(STATUS_ADDR, 8'h80);
    dev_rst_pulse <= 1'b1;
    @(posedge clk);
    dev_rst_pulse <= 1'b0;
    cyc(2);
    rd(STATUS_ADDR, 8'h00);
    wr(EVT_EN_ADDR, 8'h00);
    // monitor powered down: no trip
    wr(OPTION_ADDR, 8'h01);
    level <= 2'h0;
    cyc(20);
    chk_out(4'h0);
    // stop mode without stop enable: inactive; with it: direct trip
    level <= 2'h2;
    wr(OPTION_ADDR, 8'h00);
    stop_mode <= 1'b1;
    level <= 2'h0;
    cyc(20);
    chk_out(4'h0);
    level <= 2'h2;
    // let the stale below sample drain before the stop enable goes on
    cyc(3);
    wr(OPTION_ADDR, 8'h04);
    level <= 2'h0;
    cyc(6);
    chk_out(4'hc);
    level <= 2'h2;
    stop_mode <= 1'b0;
    cyc(5);
    chk_out(4'h0);
    cyc(2);
    summarize();
  end
endmodule : stfm_top_test
